// ---- csr_pkg.sv ----
package csr_pkg;

    localparam int unsigned CLK_PERIOD_NS = 5;

    // Register byte offsets on the APB slave
    localparam logic [7:0] OFS_CODE_BANK   = 8'h00;
    localparam logic [7:0] OFS_PTR_LOW     = 8'h04;
    localparam logic [7:0] OFS_PTR_HIGH    = 8'h08;
    localparam logic [7:0] OFS_RESULT_HIGH = 8'h0c;
    localparam logic [7:0] OFS_UNLOCK      = 8'h10;
    localparam logic [7:0] OFS_STATUS      = 8'h14;
    localparam logic [7:0] OFS_WORKING     = 8'h18;
    localparam logic [7:0] OFS_COUNTER_LOW = 8'h1c;
    localparam logic [7:0] OFS_MAP_STATE   = 8'h20;

    localparam logic [7:0] RST_CODE_BANK = 8'h00;
    localparam logic [7:0] RST_UNLOCK    = 8'h00;
    localparam logic [7:0] RST_STATUS    = 8'h00;
    localparam logic [7:0] RST_BYTE      = 8'h00;

    // Status field positions
    localparam int unsigned ST_SIGN_XOR   = 7;
    localparam int unsigned ST_CHAIN_ZERO = 6;
    localparam int unsigned ST_WDT_EXP    = 5;
    localparam int unsigned ST_HALT       = 4;
    localparam int unsigned ST_WRAP       = 3;
    localparam int unsigned ST_NULL       = 2;
    localparam int unsigned ST_HALF_CARRY = 1;
    localparam int unsigned ST_CARRY      = 0;
    localparam logic [7:0]  ST_SW_MASK    = 8'hcf;

    localparam logic [7:0] UNLOCK_FIRST  = 8'h55;
    localparam logic [7:0] UNLOCK_SECOND = 8'haa;

    // Program memory: 14-bit word address, 6-bit page above an 8-bit offset
    localparam int unsigned PM_AW         = 14;
    localparam logic [5:0]  LAST_PAGE     = 6'h3f;
    localparam logic [7:0]  OPT_WIN_BASE  = 8'hc0;
    localparam int unsigned OPT_AW        = 6;
    localparam logic [2:0]  MAP_OSC_TICKS = 3'h4;

    typedef enum logic [2:0] {
        CSR_OP_ADD,
        CSR_OP_ADC,
        CSR_OP_SUB,
        CSR_OP_SBC,
        CSR_OP_AND,
        CSR_OP_OR,
        CSR_OP_RLC,
        CSR_OP_RRC
    } csr_op_e;

    typedef struct packed {
        logic       valid;
        csr_op_e    kind;
        logic [7:0] opa;
        logic [7:0] opb;
    } csr_alu_req_s;

    typedef struct packed {
        logic       valid;
        logic       last_page;
    } csr_tbl_req_s;

    typedef struct packed {
        logic       wdt_timeout;
        logic       wdt_clear;
        logic       halt;
        logic       wake;
    } csr_sys_evt_s;

endpackage : csr_pkg

// ---- csr_core_regs.sv ----
// Notes on behaviour
// - Bank select bit picks program bank 0 or 1 for jumps and calls.
// - Bank register upper seven bits read zero; select bit resets to zero.
// - Writing counter low byte jumps within current page, with one dummy cycle.
// - Table read fetches pointer-addressed word; high byte to result register.
// - Option mapping enabled only by 55H then AAH in consecutive cycles.
// - While mapped, option words 00H-3FH answer last-page reads C0H-FFH.
// - Unlock starts timer ending mapping after four slow osc periods; restarts.
// - Unlock register resets to zero and clears on wake from idle/sleep.
// - Status is 8 bits in documented order; watchdog and halt reset zero.
// - Software status writes never change watchdog or halt flags.
// - Watchdog flag set by time-out; cleared by power-up, clear, halt.
// - Halt flag set by halt; cleared by power-up or watchdog clear.
// - Carry set on add carry or no subtract borrow; rotates update it.
// - Half carry set on low nibble carry or no nibble borrow.
// - Null flag set when result is zero, cleared otherwise; rotates leave it unchanged.
// - Wrap flag set when carry into MSB differs from carry out.
// - Sign-xor equals wrap flag XOR result MSB.
// - Chained zero: equals null on subtract, ANDs on borrow-subtract, else held.
// - Status is never saved on interrupt or call automatically.
// - Working register takes ALU results; moves pass through it.
`timescale 1ns/100ps
`default_nettype none
module csr_core_regs (
    input  wire logic                  core_clk_i,
    input  wire logic                  rst_i,
    input  wire logic                  psel_i,
    input  wire logic                  penable_i,
    input  wire logic                  pwrite_i,
    input  wire logic [7:0]            paddr_i,
    input  wire logic [31:0]           pwdata_i,
    output logic                       pready_o,
    output logic                       pslverr_o,
    output logic [31:0]                prdata_o,
    input  wire csr_pkg::csr_alu_req_s alu_req_i,
    input  wire csr_pkg::csr_tbl_req_s tbl_req_i,
    input  wire csr_pkg::csr_sys_evt_s sys_evt_i,
    input  wire logic                  slow_osc_i,
    input  wire logic [15:0]           prog_word_i,
    input  wire logic [15:0]           opt_word_i,
    output logic                       code_bank_select_bit_o,
    output logic                       jump_o,
    output logic [7:0]                 counter_low_byte_o,
    output logic                       dummy_cycle_o,
    output logic                       prog_rd_o,
    output logic [13:0]                prog_addr_o,
    output logic                       opt_rd_o,
    output logic [5:0]                 opt_addr_o,
    output logic                       tbl_done_o,
    output logic [7:0]                 tbl_low_o,
    output logic                       map_active_o,
    output logic [7:0]                 working_o,
    output logic [7:0]                 status_o
);
    import csr_pkg::*;

    logic [7:0] code_bank_register;
    logic [7:0] lookup_pointer_low;
    logic [7:0] lookup_pointer_high;
    logic [7:0] lookup_result_high;
    logic [7:0] option_map_unlock;
    logic [7:0] status;
    logic [5:0] arith_flags;
    logic [1:0] sys_flags;
    logic [7:0] working;
    logic       unlock_armed;
    logic       map_active;
    logic [2:0] osc_ticks;
    logic       osc_prev;
    logic       fetch_pending;
    logic       fetch_option;

    logic       setup_phase;
    logic       access_phase;
    logic       wr_done;
    logic       addr_hit;
    logic [7:0] wbyte;
    logic       unlock_wr;
    logic       pattern_done;
    logic       osc_rise;

    assign setup_phase  = psel_i && !penable_i;
    assign access_phase = psel_i && penable_i;
    assign wbyte        = pwdata_i[7:0];

    always_comb begin
        unique case (paddr_i)
            OFS_CODE_BANK, OFS_PTR_LOW, OFS_PTR_HIGH, OFS_RESULT_HIGH, OFS_UNLOCK,
            OFS_STATUS, OFS_WORKING, OFS_COUNTER_LOW, OFS_MAP_STATE: addr_hit = 1'b1;
            default: addr_hit = 1'b0;
        endcase
    end

    // Zero wait states; read data is captured during setup so it leaves a flop
    assign pready_o  = access_phase;
    assign pslverr_o = access_phase && !addr_hit;
    assign wr_done   = access_phase && pwrite_i && addr_hit;
    assign unlock_wr = wr_done && paddr_i == OFS_UNLOCK;

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            prdata_o <= 32'h0000_0000;
        end else if (setup_phase && !pwrite_i) begin
            unique case (paddr_i)
                OFS_CODE_BANK:   prdata_o <= {24'h000000, code_bank_register};
                OFS_PTR_LOW:     prdata_o <= {24'h000000, lookup_pointer_low};
                OFS_PTR_HIGH:    prdata_o <= {24'h000000, lookup_pointer_high};
                OFS_RESULT_HIGH: prdata_o <= {24'h000000, lookup_result_high};
                OFS_UNLOCK:      prdata_o <= {24'h000000, option_map_unlock};
                OFS_STATUS:      prdata_o <= {24'h000000, status};
                OFS_WORKING:     prdata_o <= {24'h000000, working};
                OFS_COUNTER_LOW: prdata_o <= {24'h000000, counter_low_byte_o};
                OFS_MAP_STATE:   prdata_o <= {31'h00000000, map_active};
                default:         prdata_o <= 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            code_bank_register <= RST_CODE_BANK;
        end else if (wr_done && paddr_i == OFS_CODE_BANK) begin
            code_bank_register <= {7'h00, wbyte[0]};
        end
    end
    assign code_bank_select_bit_o = code_bank_register[0];

    // Page-local jump: only the low byte is replaced, the page stays
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            counter_low_byte_o <= RST_BYTE;
            jump_o             <= 1'b0;
            dummy_cycle_o      <= 1'b0;
        end else begin
            jump_o        <= wr_done && paddr_i == OFS_COUNTER_LOW;
            dummy_cycle_o <= jump_o;
            if (wr_done && paddr_i == OFS_COUNTER_LOW) begin
                counter_low_byte_o <= wbyte;
            end
        end
    end

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            lookup_pointer_low  <= RST_BYTE;
            lookup_pointer_high <= RST_BYTE;
        end else if (wr_done) begin
            if (paddr_i == OFS_PTR_LOW) begin
                lookup_pointer_low <= wbyte;
            end
            if (paddr_i == OFS_PTR_HIGH) begin
                lookup_pointer_high <= wbyte;
            end
        end
    end

    // Unlock sequence: the second byte must be the very next completed
    // transfer, which is how a consecutive instruction cycle shows on the bus
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            option_map_unlock <= RST_UNLOCK;
            unlock_armed      <= 1'b0;
        end else begin
            if (sys_evt_i.wake) begin
                option_map_unlock <= RST_UNLOCK;
            end else if (unlock_wr) begin
                option_map_unlock <= wbyte;
            end
            if (access_phase) begin
                unlock_armed <= unlock_wr && wbyte == UNLOCK_FIRST;
            end
        end
    end
    assign pattern_done = unlock_wr && unlock_armed && wbyte == UNLOCK_SECOND;
    assign osc_rise = slow_osc_i && !osc_prev;

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            osc_prev   <= 1'b0;
            map_active <= 1'b0;
            osc_ticks  <= 3'h0;
        end else begin
            osc_prev <= slow_osc_i;
            if (pattern_done) begin
                map_active <= 1'b1;
                osc_ticks  <= 3'h0;
            end else if (map_active && osc_rise) begin
                if (osc_ticks == MAP_OSC_TICKS - 3'h1) begin
                    map_active <= 1'b0;
                    osc_ticks  <= 3'h0;
                end else begin
                    osc_ticks <= osc_ticks + 3'h1;
                end
            end
        end
    end
    assign map_active_o = map_active;

    // Table read: address now, word one cycle later
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            prog_rd_o     <= 1'b0;
            prog_addr_o   <= 14'h0000;
            opt_rd_o      <= 1'b0;
            opt_addr_o    <= 6'h00;
            fetch_pending <= 1'b0;
            fetch_option  <= 1'b0;
        end else begin
            fetch_pending <= tbl_req_i.valid;
            prog_rd_o     <= 1'b0;
            opt_rd_o      <= 1'b0;
            if (tbl_req_i.valid) begin
                if (tbl_req_i.last_page) begin
                    prog_addr_o <= {LAST_PAGE, lookup_pointer_low};
                end else begin
                    prog_addr_o <= {lookup_pointer_high[5:0], lookup_pointer_low};
                end
                opt_addr_o <= lookup_pointer_low[5:0];
                if (map_active && lookup_pointer_low >= OPT_WIN_BASE &&
                    (tbl_req_i.last_page || lookup_pointer_high[5:0] == LAST_PAGE)) begin
                    opt_rd_o     <= 1'b1;
                    fetch_option <= 1'b1;
                end else begin
                    prog_rd_o    <= 1'b1;
                    fetch_option <= 1'b0;
                end
            end
        end
    end

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            lookup_result_high <= RST_BYTE;
            tbl_low_o          <= RST_BYTE;
            tbl_done_o         <= 1'b0;
        end else begin
            tbl_done_o <= fetch_pending;
            if (fetch_pending) begin
                if (fetch_option) begin
                    lookup_result_high <= opt_word_i[15:8];
                    tbl_low_o          <= opt_word_i[7:0];
                end else begin
                    lookup_result_high <= prog_word_i[15:8];
                    tbl_low_o          <= prog_word_i[7:0];
                end
            end
        end
    end

    // Arithmetic datapath; subtraction is a + ~b + carry, so carry = no borrow
    logic [8:0] sum;
    logic [4:0] nib;
    logic [7:0] b_eff;
    logic       cin;
    logic       arith;
    logic       carry_into_msb;
    logic [7:0] next_result;
    logic       next_carry;
    logic [7:0] next_status;

    always_comb begin
        b_eff = alu_req_i.opb;
        cin   = 1'b0;
        arith = 1'b1;
        unique case (alu_req_i.kind)
            CSR_OP_ADD: cin = 1'b0;
            CSR_OP_ADC: cin = status[ST_CARRY];
            CSR_OP_SUB: begin
                b_eff = ~alu_req_i.opb;
                cin   = 1'b1;
            end
            CSR_OP_SBC: begin
                b_eff = ~alu_req_i.opb;
                cin   = status[ST_CARRY];
            end
            CSR_OP_AND, CSR_OP_OR, CSR_OP_RLC, CSR_OP_RRC: arith = 1'b0;
        endcase
        sum            = {1'b0, alu_req_i.opa} + {1'b0, b_eff} + {8'h00, cin};
        nib            = {1'b0, alu_req_i.opa[3:0]} + {1'b0, b_eff[3:0]} + {4'h0, cin};
        carry_into_msb = alu_req_i.opa[7] ^ b_eff[7] ^ sum[7];
        next_result    = sum[7:0];
        next_carry     = sum[8];
        unique case (alu_req_i.kind)
            CSR_OP_AND: next_result = alu_req_i.opa & alu_req_i.opb;
            CSR_OP_OR:  next_result = alu_req_i.opa | alu_req_i.opb;
            CSR_OP_RLC: begin
                next_result = {alu_req_i.opa[6:0], status[ST_CARRY]};
                next_carry  = alu_req_i.opa[7];
            end
            CSR_OP_RRC: begin
                next_result = {status[ST_CARRY], alu_req_i.opa[7:1]};
                next_carry  = alu_req_i.opa[0];
            end
            default: next_result = sum[7:0];
        endcase
    end

    always_comb begin
        next_status = status;
        if (alu_req_i.kind == CSR_OP_RLC || alu_req_i.kind == CSR_OP_RRC) begin
            next_status[ST_CARRY] = next_carry;
        end else begin
            next_status[ST_NULL] = next_result == 8'h00;
        end
        if (arith) begin
            next_status[ST_CARRY]      = next_carry;
            next_status[ST_HALF_CARRY] = nib[4];
            next_status[ST_WRAP]       = carry_into_msb ^ sum[8];
            next_status[ST_SIGN_XOR]   = carry_into_msb ^ sum[8] ^ next_result[7];
        end
        if (alu_req_i.kind == CSR_OP_SUB) begin
            next_status[ST_CHAIN_ZERO] = next_result == 8'h00;
        end else if (alu_req_i.kind == CSR_OP_SBC) begin
            next_status[ST_CHAIN_ZERO] = status[ST_CHAIN_ZERO] && next_result == 8'h00;
        end
    end

    // Working register: ALU results land here; software may load it directly
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            working <= RST_BYTE;
        end else if (alu_req_i.valid) begin
            working <= next_result;
        end else if (wr_done && paddr_i == OFS_WORKING) begin
            working <= wbyte;
        end
    end
    assign working_o = working;

    // Arithmetic flags; an instruction in the same cycle beats a bus write
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            arith_flags <= {RST_STATUS[7:6], RST_STATUS[3:0]};
        end else if (alu_req_i.valid) begin
            arith_flags <= {next_status[7:6], next_status[3:0]};
        end else if (wr_done && paddr_i == OFS_STATUS) begin
            arith_flags <= {wbyte[7:6], wbyte[3:0]};
        end
    end
    // System flags: own register so the bus never reaches them; a set beats a clear
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            sys_flags <= RST_STATUS[5:4];
        end else begin
            if (sys_evt_i.wdt_timeout) begin
                sys_flags[1] <= 1'b1;
            end else if (sys_evt_i.wdt_clear || sys_evt_i.halt) begin
                sys_flags[1] <= 1'b0;
            end
            if (sys_evt_i.halt) begin
                sys_flags[0] <= 1'b1;
            end else if (sys_evt_i.wdt_clear) begin
                sys_flags[0] <= 1'b0;
            end
        end
    end
    assign status   = {arith_flags[5:4], sys_flags, arith_flags[3:0]};
    // No stack port exists; callers save the status byte themselves
    assign status_o = status;

    bank_reads_zero_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        code_bank_register[7:1] == 7'h00) else $error("bank upper bits nonzero");
    jump_dummy_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        wr_done && paddr_i == OFS_COUNTER_LOW |=> jump_o ##1 dummy_cycle_o)
        else $error("page jump without dummy cycle");
    unlock_pair_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        $rose(map_active) |-> $past(unlock_wr) && $past(wbyte) == UNLOCK_SECOND)
        else $error("mapping began without pattern");
    map_timeout_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        $fell(map_active) |-> $past(osc_rise) && $past(osc_ticks) == 3'h3)
        else $error("mapping ended at wrong tick");
    wake_clears_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        sys_evt_i.wake |=> option_map_unlock == 8'h00)
        else $error("unlock register kept after wake");
    sw_keeps_sys_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        !sys_evt_i.wdt_timeout && !sys_evt_i.wdt_clear && !sys_evt_i.halt
        |=> $stable(status[5:4])) else $error("system flag moved without cause");
    wdt_flag_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        sys_evt_i.wdt_timeout |=> status[ST_WDT_EXP]) else $error("timeout not flagged");
    halt_flag_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        sys_evt_i.halt |=> status[ST_HALT] && !status[ST_WDT_EXP] ||
        $past(sys_evt_i.wdt_timeout)) else $error("halt flags wrong");
    null_flag_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        alu_req_i.valid && alu_req_i.kind == CSR_OP_SUB
        |=> status[ST_NULL] == (working == 8'h00) && status[ST_CHAIN_ZERO] == status[ST_NULL])
        else $error("zero flags wrong after subtract");
    table_high_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        tbl_req_i.valid && !opt_rd_o ##1 !fetch_option
        |=> tbl_done_o && lookup_result_high == $past(prog_word_i[15:8]))
        else $error("table high byte wrong");

endmodule : csr_core_regs
`default_nettype wire

// ---- test_core_special_registers.sv ----
`timescale 1ns/100ps
`default_nettype none
module test_core_special_registers;
    import csr_pkg::*;
    logic         core_clk, rst, psel, penable, pwrite, osc, pready, perr, err;
    logic         bank, jmp, dmy, prd, ord, tdone, mact;
    logic [7:0]   paddr, clow, tlow, work, stat, exp_st, v;
    logic [31:0]  pwdata, prdata, rd;
    logic [15:0]  pword, oword, ar;
    logic [13:0]  prog_a;
    logic [5:0]   opt_a;
    logic [3:0]   evt;
    csr_alu_req_s alu;
    csr_tbl_req_s tbl;
    integer       seed = 32'h1dff416f;
    int           fail_count = 0, cmp_count = 0, cyc = 0;

    csr_core_regs u_dut (.core_clk_i(core_clk), .rst_i(rst), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .pready_o(pready),
        .pslverr_o(perr), .prdata_o(prdata), .alu_req_i(alu), .tbl_req_i(tbl),
        .sys_evt_i(csr_sys_evt_s'(evt)), .slow_osc_i(osc), .prog_word_i(pword),
        .opt_word_i(oword), .code_bank_select_bit_o(bank), .jump_o(jmp),
        .counter_low_byte_o(clow), .dummy_cycle_o(dmy), .prog_rd_o(prd), .prog_addr_o(prog_a),
        .opt_rd_o(ord), .opt_addr_o(opt_a), .tbl_done_o(tdone), .tbl_low_o(tlow),
        .map_active_o(mact), .working_o(work), .status_o(stat));

    initial begin
        core_clk = 0;
        forever #2.5 core_clk = ~core_clk;
    end
    task give_verdict;
        if (fail_count == 0 && cmp_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : give_verdict
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 20000) begin
            fail_count++;
            give_verdict();
        end
    end
    task chk(input logic [31:0] got, input logic [31:0] e);
        cmp_count++;
        if (got !== e) begin
            fail_count++;
            $display("[ERR] %0t mismatch got %h exp %h", $time, got, e);
        end
    endtask : chk
    // Slave answers with no fixed latency assumed; the global cycle ceiling ends a hang
    task automatic apb(input logic wr, input logic [7:0] ad, input logic [31:0] d);
        @(posedge core_clk);
        psel <= 1; penable <= 0; pwrite <= wr; paddr <= ad; pwdata <= d;
        @(posedge core_clk);
        penable <= 1;
        do @(posedge core_clk); while (pready !== 1'b1);
        rd = prdata;
        err = perr;
        psel <= 0; penable <= 0;
    endtask : apb
    task rchk(input logic [7:0] ad, input logic [31:0] e);
        apb(0, ad, 0);
        chk(rd, e);
    endtask : rchk
    task pulse_evt(input logic [3:0] e);
        @(posedge core_clk) evt <= e;
        @(posedge core_clk) evt <= 4'h0;
        #1;
    endtask : pulse_evt
    task osc_rise(input int k);
        repeat (k) begin
            repeat (3) @(posedge core_clk) osc <= 1;
            repeat (3) @(posedge core_clk) osc <= 0;
        end
        #1;
    endtask : osc_rise
    task unlock(input logic [7:0] f, input logic [7:0] s, input logic mid);
        apb(1, OFS_UNLOCK, {24'h0, f});
        if (mid) apb(1, OFS_CODE_BANK, 0);
        apb(1, OFS_UNLOCK, {24'h0, s});
        repeat (2) @(posedge core_clk);
        #1;
    endtask : unlock
    task tread(input logic [7:0] lo, input logic [7:0] hi, input logic lp, input logic m);
        apb(1, OFS_PTR_LOW, {24'h0, lo});
        apb(1, OFS_PTR_HIGH, {24'h0, hi});
        pword <= 16'($random(seed));
        oword <= 16'($random(seed));
        @(posedge core_clk) tbl <= '{1'b1, lp};
        @(posedge core_clk) tbl.valid <= 0;
        #1;
        chk(m ? ord : prd, 1);
        chk(m ? 14'(opt_a) : prog_a, m ? 14'(lo[5:0]) : {hi[5:0], lo});
        ar = m ? oword : pword;
        @(posedge core_clk);
        #1;
        chk(tdone, 1);
        chk(tlow, ar[7:0]);
        rchk(OFS_RESULT_HIGH, ar[15:8]);
    endtask : tread
    function automatic logic [15:0] alu_f(csr_op_e k, logic [7:0] a, logic [7:0] b, logic [7:0] st);
        logic [8:0] s;
        logic [4:0] h;
        logic [7:0] bb, r, n;
        logic       ci;
        n = st;
        bb = (k == CSR_OP_SUB || k == CSR_OP_SBC) ? ~b : b;
        ci = (k == CSR_OP_ADD) ? 1'b0 : (k == CSR_OP_SUB) ? 1'b1 : st[0];
        s = a + bb + ci;
        h = a[3:0] + bb[3:0] + ci;
        r = s[7:0];
        case (k)
            CSR_OP_AND: r = a & b;
            CSR_OP_OR:  r = a | b;
            CSR_OP_RLC: r = {a[6:0], st[0]};
            CSR_OP_RRC: r = {st[0], a[7:1]};
            default: begin
                n[0] = s[8];
                n[1] = h[4];
                n[3] = a[7] ^ bb[7] ^ r[7] ^ s[8];
                n[7] = n[3] ^ r[7];
            end
        endcase
        if (k == CSR_OP_RLC) n[0] = a[7];
        if (k == CSR_OP_RRC) n[0] = a[0];
        if (k != CSR_OP_RLC && k != CSR_OP_RRC) n[2] = (r == 8'h00);
        if (k == CSR_OP_SUB) n[6] = n[2];
        if (k == CSR_OP_SBC) n[6] = st[6] & n[2];
        return {r, n};
    endfunction : alu_f
    task alu_op(input csr_op_e k, input logic [7:0] a, input logic [7:0] b);
        ar = alu_f(k, a, b, exp_st);
        @(posedge core_clk) alu <= '{1'b1, k, a, b};
        @(posedge core_clk) alu.valid <= 0;
        #1;
        chk(work, ar[15:8]);
        chk(stat, ar[7:0]);
        exp_st = ar[7:0];
    endtask : alu_op

    initial begin
        rst = 1; psel = 0; penable = 0; pwrite = 0; paddr = 8'h00; pwdata = 0; osc = 0;
        pword = 16'h0000; oword = 16'h0000; evt = 4'h0; alu = '0; tbl = '0;
        repeat (2) @(posedge core_clk);
        rst <= 0;
        rchk(OFS_CODE_BANK, 0);
        rchk(OFS_UNLOCK, 0);
        rchk(OFS_STATUS, 0);
        apb(1, OFS_CODE_BANK, 32'hff);
        rchk(OFS_CODE_BANK, 1);
        chk(bank, 1);
        apb(0, 8'h24, 0);
        chk(err, 1);
        chk(rd, 0);
        pulse_evt(4'b0010);
        chk(stat[5:4], 2'b01);
        pulse_evt(4'b1000);
        chk(stat[5:4], 2'b11);
        apb(1, OFS_STATUS, 0);
        rchk(OFS_STATUS, 8'h30);
        pulse_evt(4'b0010);
        chk(stat[5:4], 2'b01);
        pulse_evt(4'b0100);
        chk(stat[5:4], 2'b00);
        v = 8'($random(seed));
        apb(1, OFS_STATUS, {24'h0, v});
        exp_st = v & ST_SW_MASK;
        rchk(OFS_STATUS, exp_st);
        // Corners force carry, wrap and a zero SBC result on a nonzero chain before the random mix
        alu_op(CSR_OP_ADD, 8'hff, 8'h01);
        alu_op(CSR_OP_SUB, 8'h80, 8'h01);
        alu_op(CSR_OP_SBC, 8'h00, 8'h00);
        for (int i = 0; i < 64; i++) alu_op(csr_op_e'(i % 8), 8'($random(seed)), 8'($random(seed)));
        apb(1, OFS_WORKING, 32'h3c);
        rchk(OFS_WORKING, 32'h3c);
        apb(1, OFS_COUNTER_LOW, 32'h5a);
        #1;
        chk({jmp, clow}, 9'h15a);
        @(posedge core_clk);
        #1;
        chk({jmp, dmy}, 2'b01);
        rchk(OFS_COUNTER_LOW, 32'h5a);
        tread(8'($random(seed)), 8'h12, 0, 0);
        unlock(UNLOCK_FIRST, UNLOCK_SECOND, 0);
        chk(mact, 1);
        rchk(OFS_MAP_STATE, 1);
        tread(8'hc0 | 8'($random(seed)), 8'h00, 1, 1);
        tread(8'hff, {2'b00, LAST_PAGE}, 0, 1);
        osc_rise(2);
        unlock(UNLOCK_FIRST, UNLOCK_SECOND, 0);
        osc_rise(3);
        chk(mact, 1);
        osc_rise(1);
        chk(mact, 0);
        unlock(UNLOCK_FIRST, UNLOCK_SECOND, 1);
        chk(mact, 0);
        unlock(UNLOCK_FIRST, 8'hab, 0);
        chk(mact, 0);
        tread(8'hc4, {2'b00, LAST_PAGE}, 1, 0);
        apb(1, OFS_UNLOCK, 32'h55);
        pulse_evt(4'b0001);
        rchk(OFS_UNLOCK, 0);
        give_verdict();
    end
endmodule : test_core_special_registers
`default_nettype wire
